// [rtl/charger_pkg.sv]
package charger_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned CLK_HZ = CLK_MHZ * 1000000;
	// Least settling time of the divider before a comparator sample.
	localparam int unsigned THERM_SETTLE_NS = 2000;
	localparam int unsigned THERM_SETTLE_CYC = (THERM_SETTLE_NS * CLK_MHZ + 999) / 1000;
	// Bit period of the modulator in low-current mode.
	localparam int unsigned LOW_BIT_MS = 45;
	localparam int unsigned LOW_BIT_CYC = (CLK_HZ / 1000) * LOW_BIT_MS;

	// ==========================================================
	// Register map, byte offsets
	localparam logic [7:0] OFF_CURRENT = 8'h00;
	localparam logic [7:0] OFF_VOLTAGE = 8'h04;
	localparam logic [7:0] OFF_CONTROL = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam int unsigned CTRL_WAKE_BIT = 0;
	localparam int unsigned CTRL_INHIBIT_BIT = 1;
	localparam int unsigned CTRL_ALERT_CLR_BIT = 2;
	localparam logic [15:0] CURRENT_RESET = 16'h0000;
	localparam logic [15:0] VOLTAGE_RESET = 16'h0000;

	// ==========================================================
	// Strap thresholds as 8-bit fractions of the logic supply
	localparam logic [7:0] LVL_009 = 8'h17;
	localparam logic [7:0] LVL_017 = 8'h2C;
	localparam logic [7:0] LVL_034 = 8'h57;
	localparam logic [7:0] LVL_042 = 8'h6C;
	localparam logic [7:0] LVL_059 = 8'h97;
	localparam logic [7:0] LVL_066 = 8'hA9;
	localparam logic [7:0] LVL_084 = 8'hD7;
	localparam logic [7:0] LVL_091 = 8'hE9;

	// ==========================================================
	// Current and voltage scaling
	localparam logic [15:0] CUR_FS_BASE_MA = 16'h03FF;
	localparam logic [15:0] WAKE_MA = 16'h0050;
	localparam logic [9:0] LOW_CODE = 10'h040;
	localparam logic [11:0] DS_MOD = 12'h4FF;
	localparam logic [15:0] VREF_MV = 16'h09A1;
	localparam logic [4:0][15:0] VMAX_MV = {16'h8000, 16'h5240, 16'h41E0, 16'h3160, 16'h20F0};
	localparam logic [4:0][2:0] VSTEP_SH = {3'h5, 3'h5, 3'h5, 3'h4, 3'h4};

	// ==========================================================
	// Types
	typedef enum logic [1:0]
	{
		CUR_R1023 = 2'b00,
		CUR_R2046 = 2'b01,
		CUR_R4092 = 2'b10,
		CUR_R8184 = 2'b11
	} cur_range_t;

	typedef enum logic [2:0]
	{
		VOLT_R8432 = 3'b000,
		VOLT_R12640 = 3'b001,
		VOLT_R16864 = 3'b010,
		VOLT_R21056 = 3'b011,
		VOLT_R32768 = 3'b100
	} volt_range_t;

	typedef enum logic [1:0]
	{
		TH_OVERRANGE = 2'b00,
		TH_RANGE = 2'b01,
		TH_UNDER = 2'b10
	} therm_state_t;

	typedef struct packed
	{
		logic overrange;
		logic underrange;
		logic hot;
		logic cold;
		logic battery;
	} therm_flags_t;

	typedef struct packed
	{
		logic overrange;
		logic cold;
		logic hot;
		logic underrange;
	} therm_cmp_t;

	typedef struct packed
	{
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

endpackage

// [rtl/charger_limit_and_dac_control.sv]
`timescale 1ns/10ps

module charger_limit_and_dac_control #(
	parameter int unsigned LOW_BIT_CYCLES = charger_pkg::LOW_BIT_CYC
)(
	input wire logic clock,
	input wire logic rst_b,
	input wire charger_pkg::apb_req_t apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic adapter_present_flag,
	input wire charger_pkg::therm_cmp_t therm_cmp,
	input wire logic [7:0] current_scale_pin,
	input wire logic [7:0] voltage_limit_level,
	output logic range_switch_on,
	output logic under_switch_on,
	output logic [15:0] voltage_dac,
	output logic current_dac_switch,
	output logic charge_enable_out,
	output logic host_alert_n
);
	import charger_pkg::*;

	localparam int unsigned TMR_W = $clog2(LOW_BIT_CYCLES + 1);
	localparam int unsigned SET_W = $clog2(THERM_SETTLE_CYC + 1);

	logic [15:0] req_cur_ff;
	logic [15:0] req_volt_ff;
	logic wake_ff;
	logic inhibit_ff;
	logic adapter_ff;
	cur_range_t cur_range_ff;
	volt_range_t volt_range_ff;
	therm_state_t th_state_ff;
	therm_state_t nxt_th_state;
	logic [SET_W-1:0] settle_ff;
	therm_flags_t flags_ff;
	therm_flags_t nxt_flags;
	logic refresh_req_ff;
	logic refresh_run_ff;
	logic refresh_done_ff;
	logic volt_over_ff;
	logic alert_ff;
	logic [10:0] acc_ff;
	logic ds_bit_ff;
	logic [TMR_W-1:0] bit_tmr_ff;
	logic [2:0] pwm_ff;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic range_sw_ff;
	logic under_sw_ff;
	logic [15:0] vdac_ff;
	logic dac_sw_ff;
	logic chg_en_ff;
	logic alert_n_ff;

	// ==========================================================
	// Register bus decode
	// Answers come from flops, so a plain access takes one wait cycle.
	wire access = apb_req.psel && apb_req.penable;
	wire setup = apb_req.psel && !apb_req.penable;
	wire hit_cur = apb_req.paddr == OFF_CURRENT;
	wire hit_volt = apb_req.paddr == OFF_VOLTAGE;
	wire hit_ctrl = apb_req.paddr == OFF_CONTROL;
	wire hit_stat = apb_req.paddr == OFF_STATUS;
	wire mapped = hit_cur || hit_volt || hit_ctrl || hit_stat;
	wire stat_read = !apb_req.pwrite && hit_stat;
	// A status read is held until a pass started after its setup has finished.
	wire may_answer = !stat_read || refresh_done_ff;
	wire nxt_pready = access && !pready_ff && may_answer;
	wire xfer_done = access && pready_ff;
	wire wr_done = xfer_done && apb_req.pwrite && mapped;
	wire alert_clr = wr_done && hit_ctrl && apb_req.pwdata[CTRL_ALERT_CLR_BIT];
	wire [31:0] stat_word = {19'h00000, volt_range_ff, cur_range_ff, alert_ff, volt_over_ff,
		adapter_ff, flags_ff.battery, flags_ff.overrange, flags_ff.cold, flags_ff.hot,
		flags_ff.underrange};
	wire [31:0] rd_word = hit_cur ? {16'h0000, req_cur_ff} :
		hit_volt ? {16'h0000, req_volt_ff} :
		hit_ctrl ? {30'h00000000, inhibit_ff, wake_ff} :
		hit_stat ? stat_word : 32'h00000000;

	// ==========================================================
	// Strap decode
	// Levels between bands keep the last range, which gives noise immunity.
	wire [7:0] il = current_scale_pin;
	wire [7:0] vl = voltage_limit_level;
	cur_range_t nxt_cur_range;
	volt_range_t nxt_volt_range;
	assign nxt_cur_range = (il < LVL_009) ? CUR_R1023 :
		(il > LVL_017 && il < LVL_034) ? CUR_R2046 :
		(il > LVL_042 && il < LVL_059) ? CUR_R4092 :
		(il > LVL_066) ? CUR_R8184 : cur_range_ff;
	assign nxt_volt_range = (vl < LVL_009) ? VOLT_R8432 :
		(vl > LVL_017 && vl < LVL_034) ? VOLT_R12640 :
		(vl > LVL_042 && vl < LVL_059) ? VOLT_R16864 :
		(vl > LVL_066 && vl < LVL_084) ? VOLT_R21056 :
		(vl > LVL_091) ? VOLT_R32768 : volt_range_ff;

	// ==========================================================
	// Voltage path
	wire [15:0] vmax_mv = VMAX_MV[volt_range_ff];
	wire [2:0] vstep_sh = VSTEP_SH[volt_range_ff];
	wire volt_over = req_volt_ff > vmax_mv;
	wire volt_below = req_volt_ff < VREF_MV;
	wire [15:0] volt_target = volt_over ? vmax_mv : req_volt_ff;
	wire [15:0] volt_offset = volt_target - VREF_MV;
	wire [15:0] step_mask = (16'h0001 << vstep_sh) - 16'h0001;
	wire [15:0] nxt_vdac = volt_below ? 16'h0000 : (volt_offset & ~step_mask);
	// Charge enable also drops without the adapter.
	wire nxt_chg_en = adapter_ff && !inhibit_ff && (req_volt_ff != 16'h0000);

	// ==========================================================
	// Current path
	wire [15:0] cur_fs_ma = CUR_FS_BASE_MA << cur_range_ff;
	wire [15:0] cur_clamped = (req_cur_ff >= cur_fs_ma) ? cur_fs_ma : req_cur_ff;
	wire [15:0] cur_steps = cur_clamped >> cur_range_ff;
	wire [15:0] wake_steps = WAKE_MA >> cur_range_ff;
	wire [9:0] ds_code = wake_ff ? wake_steps[9:0] : cur_steps[9:0];
	wire low_mode = ds_code < LOW_CODE;
	// Low mode feeds eight times the code so that the 1/8 gate averages to the request.
	wire [10:0] ds_in = low_mode ? {ds_code[7:0], 3'b000} : {1'b0, ds_code};
	wire [11:0] ds_sum = {1'b0, acc_ff} + {1'b0, ds_in};
	wire ds_carry = ds_sum >= DS_MOD;
	wire [11:0] ds_rem = ds_carry ? (ds_sum - DS_MOD) : ds_sum;
	wire tmr_zero = bit_tmr_ff == '0;
	wire ds_step = !low_mode || tmr_zero;
	wire pwm_pulse = pwm_ff == 3'b000;
	wire nxt_dac_sw = low_mode ? (ds_bit_ff && pwm_pulse) : ds_bit_ff;

	// ==========================================================
	// Thermistor sensing
	// The settle counter restarts on each state change before a sample is taken.
	wire settled = settle_ff == SET_W'(THERM_SETTLE_CYC - 1);
	wire full_mode = adapter_ff || refresh_run_ff;
	wire pass_start = (th_state_ff == TH_OVERRANGE) && (settle_ff == '0);
	wire pass_end = settled && ((th_state_ff == TH_OVERRANGE && (therm_cmp.overrange ||
		!full_mode)) || (th_state_ff == TH_RANGE && !therm_cmp.hot) ||
		th_state_ff == TH_UNDER);
	wire nxt_battery = nxt_flags.battery;
	wire presence_event = (adapter_present_flag != adapter_ff) ||
		(nxt_battery != flags_ff.battery);
	wire nxt_alert = presence_event || (alert_ff && !alert_clr);

	always_comb
	begin
		nxt_th_state = th_state_ff;
		nxt_flags = flags_ff;
		if (settled)
		begin
			unique case (th_state_ff)
				TH_OVERRANGE:
				begin
					nxt_flags.overrange = therm_cmp.overrange;
					nxt_flags.battery = !therm_cmp.overrange;
					if (therm_cmp.overrange)
					begin
						nxt_flags.cold = 1'b1;
						nxt_flags.hot = 1'b0;
						nxt_flags.underrange = 1'b0;
					end
					else if (full_mode)
						nxt_th_state = TH_RANGE;
				end
				TH_RANGE:
				begin
					nxt_flags.cold = therm_cmp.cold;
					nxt_flags.hot = therm_cmp.hot;
					nxt_flags.underrange = 1'b0;
					nxt_th_state = therm_cmp.hot ? TH_UNDER : TH_OVERRANGE;
				end
				TH_UNDER:
				begin
					nxt_flags.underrange = therm_cmp.underrange;
					nxt_th_state = TH_OVERRANGE;
				end
				default:
					nxt_th_state = TH_OVERRANGE;
			endcase
		end
	end

	// Sensing state, settling and the read-triggered refresh.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			th_state_ff <= TH_OVERRANGE;
			settle_ff <= '0;
			flags_ff <= '0;
			refresh_req_ff <= 1'b0;
			refresh_run_ff <= 1'b0;
			refresh_done_ff <= 1'b0;
		end
		else
		begin
			th_state_ff <= nxt_th_state;
			settle_ff <= settled ? '0 : settle_ff + SET_W'(1);
			flags_ff <= nxt_flags;
			refresh_req_ff <= (setup && stat_read) || (refresh_req_ff && !xfer_done);
			refresh_run_ff <= (pass_start && refresh_req_ff && !refresh_done_ff) ||
				(refresh_run_ff && !pass_end);
			refresh_done_ff <= (refresh_run_ff && pass_end) ||
				(refresh_done_ff && !xfer_done);
		end
	end

	// ==========================================================
	// Software registers and strap holding
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			req_cur_ff <= CURRENT_RESET;
			req_volt_ff <= VOLTAGE_RESET;
			wake_ff <= 1'b0;
			inhibit_ff <= 1'b0;
			adapter_ff <= 1'b0;
			cur_range_ff <= CUR_R1023;
			volt_range_ff <= VOLT_R8432;
			volt_over_ff <= 1'b0;
			alert_ff <= 1'b0;
		end
		else
		begin
			if (wr_done && hit_cur)
				req_cur_ff <= apb_req.pwdata[15:0];
			if (wr_done && hit_volt)
				req_volt_ff <= apb_req.pwdata[15:0];
			if (wr_done && hit_ctrl)
			begin
				wake_ff <= apb_req.pwdata[CTRL_WAKE_BIT];
				inhibit_ff <= apb_req.pwdata[CTRL_INHIBIT_BIT];
			end
			adapter_ff <= adapter_present_flag;
			cur_range_ff <= nxt_cur_range;
			volt_range_ff <= nxt_volt_range;
			volt_over_ff <= volt_over;
			alert_ff <= nxt_alert;
		end
	end

	// ==========================================================
	// Delta-sigma modulator
	// Modulus 1279 against a 1023 code caps the ones density at 80 percent.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			acc_ff <= '0;
			ds_bit_ff <= 1'b0;
			bit_tmr_ff <= '0;
			pwm_ff <= 3'b000;
		end
		else
		begin
			if (ds_step)
			begin
				acc_ff <= ds_rem[10:0];
				ds_bit_ff <= ds_carry;
			end
			bit_tmr_ff <= (tmr_zero || !low_mode) ? TMR_W'(LOW_BIT_CYCLES - 1) :
				bit_tmr_ff - TMR_W'(1);
			pwm_ff <= pwm_ff + 3'b001;
		end
	end

	// ==========================================================
	// Output and bus answer flops
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			prdata_ff <= 32'h00000000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			range_sw_ff <= 1'b0;
			under_sw_ff <= 1'b0;
			vdac_ff <= 16'h0000;
			dac_sw_ff <= 1'b0;
			chg_en_ff <= 1'b0;
			alert_n_ff <= 1'b1;
		end
		else
		begin
			pready_ff <= nxt_pready;
			prdata_ff <= nxt_pready ? rd_word : prdata_ff;
			pslverr_ff <= nxt_pready && !mapped;
			range_sw_ff <= nxt_th_state == TH_RANGE;
			under_sw_ff <= nxt_th_state == TH_UNDER;
			vdac_ff <= nxt_vdac;
			dac_sw_ff <= nxt_dac_sw;
			chg_en_ff <= nxt_chg_en;
			alert_n_ff <= !nxt_alert;
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign range_switch_on = range_sw_ff;
	assign under_switch_on = under_sw_ff;
	assign voltage_dac = vdac_ff;
	assign current_dac_switch = dac_sw_ff;
	assign charge_enable_out = chg_en_ff;
	assign host_alert_n = alert_n_ff;

	// ==========================================================
	// Assertions
	a_lowpower_or_only: assert property (@(posedge clock) disable iff (!rst_b)
		(!full_mode && th_state_ff == TH_OVERRANGE) |=> th_state_ff == TH_OVERRANGE)
		else $error("range sensing ran in low power mode");
	a_refresh_on_read: assert property (@(posedge clock) disable iff (!rst_b)
		(setup && stat_read) |=> refresh_req_ff)
		else $error("status read did not request a refresh");
	a_range_after_or: assert property (@(posedge clock) disable iff (!rst_b)
		range_switch_on |-> (!flags_ff.overrange && th_state_ff == TH_RANGE))
		else $error("range switch on without low overrange");
	a_under_after_hot: assert property (@(posedge clock) disable iff (!rst_b)
		under_switch_on |-> flags_ff.hot)
		else $error("underrange sensing without hot");
	a_alert_on_change: assert property (@(posedge clock) disable iff (!rst_b)
		($changed(adapter_ff) || $changed(flags_ff.battery)) |-> !host_alert_n)
		else $error("presence change did not raise alert");
	a_vdac_zero_low: assert property (@(posedge clock) disable iff (!rst_b)
		volt_below |=> voltage_dac == 16'h0000)
		else $error("voltage below reference not zeroed");
	a_volt_clamp_flag: assert property (@(posedge clock) disable iff (!rst_b)
		volt_over |=> (volt_over_ff &&
			voltage_dac == (($past(vmax_mv) - VREF_MV) & ~$past(step_mask))))
		else $error("over-limit voltage not clamped");
	a_charge_enable_out_zero_volt: assert property (@(posedge clock) disable iff (!rst_b)
		(req_volt_ff == 16'h0000) |=> !charge_enable_out)
		else $error("charge enabled with zero voltage");
	a_low_pwm_gate: assert property (@(posedge clock) disable iff (!rst_b)
		(low_mode && pwm_ff != 3'b000) |=> !current_dac_switch)
		else $error("low mode switch outside pulse slot");
	a_low_bit_rate: assert property (@(posedge clock) disable iff (!rst_b)
		(low_mode && !tmr_zero) |=> $stable(ds_bit_ff))
		else $error("modulator stepped early in low mode");
	a_ds_max_duty: assert property (@(posedge clock) disable iff (!rst_b)
		(ds_bit_ff && !low_mode)[*4] |=> !ds_bit_ff)
		else $error("modulator exceeded its duty limit");

endmodule

// [sim/bus_host.sv]
`timescale 1ns/10ps

// ==========
// Host side of the register bus
module bus_host
(
	input wire logic clock,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	output charger_pkg::apb_req_t req
);
	import charger_pkg::*;

	initial req = '0;

	// One transfer: setup, then access held until ready is seen at an edge.
	// Released lines show inverted values so a stale address cannot pass.
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clock);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		// No limit of its own: a hung answer is left to the bench watchdog.
		do
		begin
			@(posedge clock);
		end
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		req <= '{psel: 1'b0, penable: 1'b0, pwrite: 1'b0, paddr: ~a, pwdata: ~d};
	endtask
endmodule

// [sim/tb_top.sv]
`timescale 1ns/10ps

`define CHK(nm, ex, gt) \
	begin \
		compares++; \
		if ((gt) !== (ex)) \
		begin \
			fails++; \
			$display("Error %s expected %0h seen %0h", nm, ex, gt); \
		end \
	end

module tb_top;
	import charger_pkg::*;

	// ==========
	// Signals
	localparam int LBC = 8;
	localparam int BLO[5] = '{0, 45, 109, 170, 234};
	localparam int BHI[5] = '{22, 86, 150, 214, 255};
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic adapter_present_flag = 1'b0;
	logic [7:0] current_scale_pin = 8'h00;
	logic [7:0] voltage_limit_level = 8'h00;
	logic junk = 1'b0;
	therm_cmp_t therm_cmp;
	apb_req_t apb_req;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [31:0] rng = 32'h00000053;
	logic [15:0] voltage_dac;
	logic [15:0] vl[5];
	logic pready, pslverr, range_switch_on, under_switch_on, er;
	logic current_dac_switch, charge_enable_out, host_alert_n;
	int fails = 0;
	int compares = 0;
	int therm_r = 10000;
	int ones, run, code, lim;
	int c_rg[7] = '{0, 1, 3, 3, 2, 0, 3};
	int c_rq[7] = '{0, 5000, 512, 160, 252, 0, 0};
	bit c_wk[7] = '{0, 0, 0, 0, 0, 1, 1};

	charger_limit_and_dac_control #(.LOW_BIT_CYCLES(LBC)) uut (.clock(clock), .rst_b(rst_b),
		.apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adapter_present_flag(adapter_present_flag), .therm_cmp(therm_cmp),
		.current_scale_pin(current_scale_pin), .voltage_limit_level(voltage_limit_level),
		.range_switch_on(range_switch_on), .under_switch_on(under_switch_on),
		.voltage_dac(voltage_dac), .current_dac_switch(current_dac_switch),
		.charge_enable_out(charge_enable_out), .host_alert_n(host_alert_n));

	bus_host host (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.req(apb_req));

	// Comparators whose divider is switched off read a toggling level, not a kind value.
	always @(posedge clock) junk <= ~junk;
	assign therm_cmp.overrange = therm_r > 100000;
	assign therm_cmp.cold = range_switch_on ? therm_r > 30000 : junk;
	assign therm_cmp.hot = range_switch_on ? therm_r < 3000 : junk;
	assign therm_cmp.underrange = under_switch_on ? therm_r < 500 : junk;

	initial
	begin
		forever #20 clock = ~clock;
	end

	// ==========
	// Helpers
	function automatic logic [31:0] next_rand();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [7:0] band(int k);
		return 8'(BLO[k] + next_rand() % (BHI[k] - BLO[k] + 1));
	endfunction

	// Status bits: battery, overrange, cold, hot, underrange.
	function automatic logic [4:0] therm_exp(int r);
		if (r > 100000)
			return 5'b01100;
		if (r > 30000)
			return 5'b10100;
		if (r >= 3000)
			return 5'b10000;
		if (r >= 500)
			return 5'b10010;
		return 5'b10011;
	endfunction

	function automatic logic [15:0] vexp(logic [15:0] v, int k);
		logic [15:0] c;
		c = (v > VMAX_MV[k]) ? VMAX_MV[k] : v;
		if (c < VREF_MV)
			return 16'h0000;
		return ((c - VREF_MV) >> VSTEP_SH[k]) << VSTEP_SH[k];
	endfunction

	function automatic int dac_code(int rg, int rq, bit wk);
		int fs;
		fs = 1023 << rg;
		if (wk)
			return 80 >> rg;
		return ((rq > fs) ? fs : rq) >> rg;
	endfunction

	task automatic tick(int n);
		repeat (n) @(posedge clock);
	endtask

	task automatic wr(logic [7:0] a, logic [31:0] d);
		host.xfer(1'b1, a, d, rd, er);
	endtask

	task automatic rdreg(logic [7:0] a);
		host.xfer(1'b0, a, 32'h00000000, rd, er);
	endtask

	// Counts high cycles of a pin and its longest run of consecutive highs.
	task automatic count_hi(int n, ref logic sig, output int hi, output int lng);
		int r;
		hi = 0;
		lng = 0;
		r = 0;
		repeat (n)
		begin
			@(posedge clock);
			r = (sig === 1'b1) ? r + 1 : 0;
			hi += (sig === 1'b1);
			lng = (r > lng) ? r : lng;
		end
	endtask

	task automatic give_verdict();
		$display("Counts: %0d compares, %0d fails", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// A hung handshake is cut short well past the expected run length.
	initial
	begin
		tick(100000);
		fails++;
		give_verdict();
	end

	// ==========
	// Tests
	initial
	begin
		tick(12);
		rst_b <= 1'b1;
		tick(2);
		rdreg(OFF_VOLTAGE);
		`CHK("voltage reset", 32'h00000000, rd)
		rdreg(8'h10);
		`CHK("unmapped error", 1'b1, er)
		`CHK("unmapped data", 32'h00000000, rd)
		$display("Test registers done");
		// Without the adapter only the overrange sense may run, except in a pass started by a status read.
		therm_r <= 1000;
		count_hi(400, range_switch_on, ones, run);
		`CHK("idle range switch", 0, ones)
		rdreg(OFF_STATUS);
		`CHK("idle status", therm_exp(1000), rd[4:0])
		count_hi(300, under_switch_on, ones, run);
		`CHK("after read switch", 0, ones)
		$display("Test low power done");
		// Clear the alert left by battery detection so only the adapter can raise it.
		wr(OFF_CONTROL, 32'h00000004);
		tick(2);
		`CHK("alert idle", 1'b1, host_alert_n)
		adapter_present_flag <= 1'b1;
		tick(3);
		`CHK("adapter alert", 1'b0, host_alert_n)
		wr(OFF_CONTROL, 32'h00000004);
		tick(2);
		`CHK("alert cleared", 1'b1, host_alert_n)
		foreach (BLO[i])
		begin
			therm_r <= (i == 0) ? 200 : (i == 1) ? 1000 : (i == 2) ? 10000 :
				(i == 3) ? 50000 : 200000;
			rdreg(OFF_STATUS);
			`CHK("therm flags", therm_exp(therm_r), rd[4:0])
		end
		wr(OFF_CONTROL, 32'h00000004);
		therm_r <= 10000;
		tick(400);
		`CHK("battery alert", 1'b0, host_alert_n)
		$display("Test thermistor done");
		for (int k = 0; k < 5; k++)
		begin
			current_scale_pin <= band(k % 4);
			voltage_limit_level <= band(k);
			tick(4);
			rdreg(OFF_STATUS);
			`CHK("current range", 2'(k % 4), rd[9:8])
			`CHK("voltage range", 3'(k), rd[12:10])
			vl = '{16'h0000, 16'h07D0,
				VREF_MV + 16'h0020 + 16'(next_rand() % (VMAX_MV[k] - VREF_MV - 16'h0020)),
				VMAX_MV[k], VMAX_MV[k] + 16'h0001 + 16'(next_rand() % 32'h400)};
			foreach (vl[j])
			begin
				wr(OFF_VOLTAGE, {16'h0000, vl[j]});
				tick(3);
				`CHK("voltage dac", vexp(vl[j], k), voltage_dac)
				if (j == 0)
					`CHK("enable zero", 1'b0, charge_enable_out)
				if (j == 2)
					`CHK("enable set", 1'b1, charge_enable_out)
				rdreg(OFF_STATUS);
				`CHK("volt over", vl[j] > VMAX_MV[k], rd[6])
			end
		end
		wr(OFF_CONTROL, 32'h00000002);
		tick(3);
		`CHK("enable inhibited", 1'b0, charge_enable_out)
		$display("Test voltage done");
		// Full accumulator periods make the count exact within two steps.
		c_rq[0] = 200 + int'(next_rand() % 800);
		foreach (c_rg[i])
		begin
			current_scale_pin <= band(c_rg[i]);
			wr(OFF_CURRENT, c_rq[i]);
			wr(OFF_CONTROL, {31'h00000000, c_wk[i]});
			tick(4 * LBC);
			code = dac_code(c_rg[i], c_rq[i], c_wk[i]);
			lim = (code < 64) ? 8 * code : code;
			count_hi((code < 64) ? 1279 * LBC : 1279, current_dac_switch, ones, run);
			ones = (ones >= lim - 2 && ones <= lim + 2) ? lim : ones;
			`CHK("dac ones", lim, ones)
			lim = (code < 64) ? 1 : 4;
			run = (run <= lim) ? lim : run;
			`CHK("dac run", lim, run)
		end
		$display("Test current dac done");
		give_verdict();
	end
endmodule
